// *** spa_pkg.sv ***
// Package for the scan port programming access block: TAP states,
// instruction codes, register widths, reset values and a carrier struct.
// Assumes it is compiled before spa_scan_port.sv.
`default_nettype none
package spa_pkg;
  localparam int IR_W = 4;
  localparam int PEN_W = 16;
  localparam int CMD_W = 15;
  localparam logic [3:0] IR_CORE_RST = 4'hc;
  localparam logic [3:0] IR_PROG_EN = 4'h4;
  localparam logic [3:0] IR_PROG_CMD = 4'h5;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [15:0] PEN_SIG_DEF = 16'h1234;
  localparam logic [1:0] DIS_CLR_CYCLES = 2'h2;
  localparam logic [1:0] CNT_ZERO = 2'h0;

  typedef enum logic [3:0] {
    SPA_TLR = 4'h0, SPA_RTI = 4'h1, SPA_SELDR = 4'h3, SPA_CAPDR = 4'h2,
    SPA_SHDR = 4'h6, SPA_EX1DR = 4'h7, SPA_PSDR = 4'h5, SPA_EX2DR = 4'h4,
    SPA_UPDR = 4'hc, SPA_SELIR = 4'hd, SPA_CAPIR = 4'hf, SPA_SHIR = 4'he,
    SPA_EX1IR = 4'ha, SPA_PSIR = 4'hb, SPA_EX2IR = 4'h9, SPA_UPIR = 4'h8
  } spa_tap_t;

  typedef struct packed {
    logic [CMD_W-1:0] cmd;
    logic exec;
  } spa_nvm_req_t;
endpackage
`default_nettype wire

// *** spa_scan_port.sv ***
// Scan port front end for non-volatile programming: TAP controller,
// 4-bit instruction register, core reset, enable and command chains.
// Assumes tck comes from an external controller and may stop between
// scans; tms and tdi are launched by that controller on tck.
//
// Operation
// - Port works only with enable fuse programmed and disable bit cleared.
// - Disable bit set with external reset low clears two clocks later.
// - All shift registers shift least significant bit first, in and out.
// - Instruction register is four bits wide, sixteen codes.
// - Run-Test/Idle produces internal programming clocks and idles safely; here only entry from Update-DR after a command gives one execute pulse.
// - Code 0xC selects one-bit core reset register; TAP stays unreset.
// - Core stays reset exactly while reset chain holds one.
// - Under core reset code, reset bit shifts every TCK in Shift-DR.
// - Code 0x4 selects sixteen-bit programming enable register.
// - Shift-DR shifts enable signature into enable register.
// - Update-DR compares signature; programming mode entered only on match.
// - Code 0x5 selects fifteen-bit programming command register.
// - Capture-DR loads previous command result into command register.
// - Shift-DR outputs old result on TDO while new command enters.
// - Update-DR applies shifted command to memory interface.
// - Entering Run-Test/Idle after update produces one execute clock.
`timescale 1ns/1ps
`default_nettype none
module spa_scan_port #(
  parameter logic [15:0] PEN_SIG = spa_pkg::PEN_SIG_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic scan_port_enable_fuse,
  input wire logic ext_rst_n,
  input wire logic disable_wr,
  input wire logic disable_wdata,
  output logic scan_port_disable_bit,
  output logic tap_pins_owned,
  output logic core_rst,
  output logic prog_mode,
  output spa_pkg::spa_nvm_req_t nvm_req,
  input wire logic [spa_pkg::CMD_W-1:0] nvm_result,
  input wire logic nvm_result_valid
);
  // ----------------------------------------------------------------
  // Link domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rst_s1, rst_s2, en_s1, en_s2, res_s1, res_s2, res_s3;
    spa_pkg::spa_tap_t st;
    logic [spa_pkg::IR_W-1:0] ir, irsh;
    logic rst_bit, byp, prog, upd_t, exe_t, tdo, oe;
    logic [spa_pkg::PEN_W-1:0] pen;
    logic [spa_pkg::CMD_W-1:0] cmdsh, cmd, res_hold;
  } spa_tck_t;

  // ----------------------------------------------------------------
  // Chip clock domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fuse_s1, fuse, dis, xr_s1, xr_s2;
    logic [1:0] clr_cnt;
    logic en, upd_s1, upd_s2, upd_s3, exe_s1, exe_s2, exe_s3;
    logic cr_s1, cr_s2, pg_s1, pg_s2, core_rst, res_t;
    logic [spa_pkg::CMD_W-1:0] res;
    spa_pkg::spa_nvm_req_t req;
  } spa_clk_t;

  spa_tck_t t_q, t_d;
  spa_clk_t c_q, c_d;

  // Last count value before the forced clear of the disable bit.
  localparam logic [1:0] DIS_CLR_LAST = spa_pkg::DIS_CLR_CYCLES - 2'h1;

  // Standard TAP transition table, one TMS sample per TCK.
  function automatic spa_pkg::spa_tap_t next_tap(spa_pkg::spa_tap_t s, logic m);
    case (s)
      spa_pkg::SPA_TLR: next_tap = m ? spa_pkg::SPA_TLR : spa_pkg::SPA_RTI;
      spa_pkg::SPA_RTI: next_tap = m ? spa_pkg::SPA_SELDR : spa_pkg::SPA_RTI;
      spa_pkg::SPA_SELDR: next_tap = m ? spa_pkg::SPA_SELIR : spa_pkg::SPA_CAPDR;
      spa_pkg::SPA_CAPDR: next_tap = m ? spa_pkg::SPA_EX1DR : spa_pkg::SPA_SHDR;
      spa_pkg::SPA_SHDR: next_tap = m ? spa_pkg::SPA_EX1DR : spa_pkg::SPA_SHDR;
      spa_pkg::SPA_EX1DR: next_tap = m ? spa_pkg::SPA_UPDR : spa_pkg::SPA_PSDR;
      spa_pkg::SPA_PSDR: next_tap = m ? spa_pkg::SPA_EX2DR : spa_pkg::SPA_PSDR;
      spa_pkg::SPA_EX2DR: next_tap = m ? spa_pkg::SPA_UPDR : spa_pkg::SPA_SHDR;
      spa_pkg::SPA_UPDR: next_tap = m ? spa_pkg::SPA_SELDR : spa_pkg::SPA_RTI;
      spa_pkg::SPA_SELIR: next_tap = m ? spa_pkg::SPA_TLR : spa_pkg::SPA_CAPIR;
      spa_pkg::SPA_CAPIR: next_tap = m ? spa_pkg::SPA_EX1IR : spa_pkg::SPA_SHIR;
      spa_pkg::SPA_SHIR: next_tap = m ? spa_pkg::SPA_EX1IR : spa_pkg::SPA_SHIR;
      spa_pkg::SPA_EX1IR: next_tap = m ? spa_pkg::SPA_UPIR : spa_pkg::SPA_PSIR;
      spa_pkg::SPA_PSIR: next_tap = m ? spa_pkg::SPA_EX2IR : spa_pkg::SPA_PSIR;
      spa_pkg::SPA_EX2IR: next_tap = m ? spa_pkg::SPA_UPIR : spa_pkg::SPA_SHIR;
      spa_pkg::SPA_UPIR: next_tap = m ? spa_pkg::SPA_SELDR : spa_pkg::SPA_RTI;
      default: next_tap = spa_pkg::SPA_TLR;
    endcase
  endfunction

  // Link logic. The chip reset and the port enable reach it through
  // two-stage synchronisers; the TAP is held in Test-Logic-Reset while
  // the port is not usable, so a disabled port never drives TDO.
  always_comb begin
    spa_pkg::spa_tap_t ns;
    ns = next_tap(t_q.st, tms);
    t_d = t_q;
    t_d.rst_s1 = sys_rst;
    t_d.rst_s2 = t_q.rst_s1;
    t_d.en_s1 = c_q.en;
    t_d.en_s2 = t_q.en_s1;
    t_d.res_s1 = c_q.res_t;
    t_d.res_s2 = t_q.res_s1;
    t_d.res_s3 = t_q.res_s2;
    // Result word is stable in the chip domain when its toggle arrives.
    if (t_q.res_s2 != t_q.res_s3) begin
      t_d.res_hold = c_q.res;
    end
    t_d.st = ns;
    case (t_q.st)
      spa_pkg::SPA_TLR: begin
        t_d.ir = spa_pkg::IR_BYPASS;
        t_d.prog = 1'b0;
      end
      spa_pkg::SPA_CAPIR: t_d.irsh = spa_pkg::IR_CAPTURE;
      spa_pkg::SPA_SHIR: t_d.irsh = {tdi, t_q.irsh[3:1]};
      spa_pkg::SPA_UPIR: t_d.ir = t_q.irsh;
      spa_pkg::SPA_CAPDR: begin
        if (t_q.ir == spa_pkg::IR_PROG_CMD) begin
          t_d.cmdsh = t_q.res_hold;
        end else begin
          t_d.byp = 1'b0;
        end
      end
      spa_pkg::SPA_SHDR: begin
        case (t_q.ir)
          spa_pkg::IR_CORE_RST: t_d.rst_bit = tdi;
          spa_pkg::IR_PROG_EN: t_d.pen = {tdi, t_q.pen[15:1]};
          spa_pkg::IR_PROG_CMD: t_d.cmdsh = {tdi, t_q.cmdsh[14:1]};
          default: t_d.byp = tdi;
        endcase
      end
      spa_pkg::SPA_UPDR: begin
        if (t_q.ir == spa_pkg::IR_PROG_EN) begin
          t_d.prog = (t_q.pen == PEN_SIG);
        end
        // Commands only move while programming mode is on.
        if (t_q.ir == spa_pkg::IR_PROG_CMD && t_q.prog) begin
          t_d.cmd = t_q.cmdsh;
          t_d.upd_t = ~t_q.upd_t;
          if (ns == spa_pkg::SPA_RTI) begin
            t_d.exe_t = ~t_q.exe_t;
          end
        end
      end
      default: t_d.st = ns;
    endcase
    // TDO shows the bit that the controller samples at the next edge.
    t_d.oe = (ns == spa_pkg::SPA_SHDR) || (ns == spa_pkg::SPA_SHIR);
    if (ns == spa_pkg::SPA_SHIR) begin
      t_d.tdo = t_d.irsh[0];
    end else begin
      case (t_q.ir)
        spa_pkg::IR_CORE_RST: t_d.tdo = t_d.rst_bit;
        spa_pkg::IR_PROG_EN: t_d.tdo = t_d.pen[0];
        spa_pkg::IR_PROG_CMD: t_d.tdo = t_d.cmdsh[0];
        default: t_d.tdo = t_d.byp;
      endcase
    end
    // Core reset chain survives a TAP reset on purpose.
    if (t_q.rst_s2 || !t_q.en_s2) begin
      t_d.st = spa_pkg::SPA_TLR;
      t_d.ir = spa_pkg::IR_BYPASS;
      t_d.prog = 1'b0;
      t_d.oe = 1'b0;
      t_d.tdo = 1'b0;
    end
    // Chip reset clears every link register but the IR, which loads bypass, so
    // the toggles and shift registers start from known values; the synchroniser stages run on.
    if (t_q.rst_s2) begin
      t_d = '0;
      t_d.rst_s1 = sys_rst;
      t_d.rst_s2 = t_q.rst_s1;
      t_d.en_s1 = c_q.en;
      t_d.en_s2 = t_q.en_s1;
      t_d.res_s1 = c_q.res_t;
      t_d.res_s2 = t_q.res_s1;
      t_d.res_s3 = t_q.res_s2;
      t_d.st = spa_pkg::SPA_TLR;
      t_d.ir = spa_pkg::IR_BYPASS;
    end
  end

  always_ff @(posedge tck) begin
    t_q <= t_d;
  end

  // Chip side: disable bit, enable level, and event crossings. The
  // command word is read only after its toggle is synchronised; the next
  // update needs a whole scan, far longer than the crossing latency.
  always_comb begin
    c_d = c_q;
    // The fuse is a pin level, so it passes two flip-flops like the others.
    c_d.fuse_s1 = scan_port_enable_fuse;
    c_d.fuse = c_q.fuse_s1;
    c_d.xr_s1 = ext_rst_n;
    c_d.xr_s2 = c_q.xr_s1;
    c_d.upd_s1 = t_q.upd_t;
    c_d.upd_s2 = c_q.upd_s1;
    c_d.upd_s3 = c_q.upd_s2;
    c_d.exe_s1 = t_q.exe_t;
    c_d.exe_s2 = c_q.exe_s1;
    c_d.exe_s3 = c_q.exe_s2;
    c_d.cr_s1 = t_q.rst_bit;
    c_d.cr_s2 = c_q.cr_s1;
    c_d.pg_s1 = t_q.prog;
    c_d.pg_s2 = c_q.pg_s1;
    c_d.core_rst = c_q.cr_s2;
    c_d.req.exec = 1'b0;
    // External reset low forces the disable bit clear after two clocks.
    if (c_q.dis && !c_q.xr_s2) begin
      c_d.clr_cnt = c_q.clr_cnt + 2'h1;
      if (c_q.clr_cnt == DIS_CLR_LAST) begin
        c_d.dis = 1'b0;
        c_d.clr_cnt = spa_pkg::CNT_ZERO;
      end
    end else begin
      c_d.clr_cnt = spa_pkg::CNT_ZERO;
    end
    // A software write in the same cycle wins over the forced clear.
    if (disable_wr) begin
      c_d.dis = disable_wdata;
    end
    c_d.en = c_q.fuse && !c_q.dis;
    if (c_q.upd_s2 != c_q.upd_s3 && c_q.pg_s2) begin
      c_d.req.cmd = t_q.cmd;
    end
    if (c_q.exe_s2 != c_q.exe_s3 && c_q.pg_s2) begin
      c_d.req.exec = 1'b1;
    end
    if (nvm_result_valid) begin
      c_d.res = nvm_result;
      c_d.res_t = ~c_q.res_t;
    end
    if (sys_rst) begin
      c_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (ce || sys_rst) begin
      c_q <= c_d;
    end
  end

  assign tdo = t_q.tdo;
  assign tdo_oe = t_q.oe;
  assign scan_port_disable_bit = c_q.dis;
  assign tap_pins_owned = c_q.en;
  assign core_rst = c_q.core_rst;
  assign prog_mode = c_q.pg_s2;
  assign nvm_req = c_q.req;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ir_shift_lsb_a: assert property (@(posedge tck) disable iff (t_q.rst_s2)
    (t_q.st == spa_pkg::SPA_SHIR && t_q.en_s2) |=> t_q.irsh[3] == $past(tdi))
    else $error("IR did not shift TDI into its top bit.");
  ir_load_a: assert property (@(posedge tck) disable iff (t_q.rst_s2)
    (t_q.st == spa_pkg::SPA_UPIR && t_q.en_s2) |=> t_q.ir == $past(t_q.irsh))
    else $error("IR not loaded on Update-IR.");
  sig_check_a: assert property (@(posedge tck) disable iff (t_q.rst_s2)
    (t_q.st == spa_pkg::SPA_UPDR && t_q.ir == spa_pkg::IR_PROG_EN && t_q.en_s2)
    |=> t_q.prog == ($past(t_q.pen) == PEN_SIG))
    else $error("Programming mode does not follow the signature check.");
  cmd_capture_a: assert property (@(posedge tck) disable iff (t_q.rst_s2)
    (t_q.st == spa_pkg::SPA_CAPDR && t_q.ir == spa_pkg::IR_PROG_CMD && t_q.en_s2)
    |=> t_q.cmdsh == $past(t_q.res_hold))
    else $error("Previous result not captured.");
  exec_once_a: assert property (@(posedge tck) disable iff (t_q.rst_s2)
    $changed(t_q.exe_t) |-> t_q.st == spa_pkg::SPA_RTI && $past(t_q.prog))
    else $error("Execute clock outside Run-Test/Idle entry.");
  bypass_path_a: assert property (@(posedge tck) disable iff (t_q.rst_s2)
    (t_q.st == spa_pkg::SPA_SHDR && t_q.ir != spa_pkg::IR_CORE_RST && t_q.en_s2
    && t_q.ir != spa_pkg::IR_PROG_EN && t_q.ir != spa_pkg::IR_PROG_CMD
    && next_tap(t_q.st, tms) == spa_pkg::SPA_SHDR) |=> t_q.tdo == $past(tdi))
    else $error("Bypass bit not passed to TDO.");
  port_gate_a: assert property (@(posedge tck)
    !t_q.en_s2 |=> !t_q.oe && t_q.st == spa_pkg::SPA_TLR)
    else $error("Port active while disabled.");
  dis_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (c_q.dis && !c_q.xr_s2 && !disable_wr && ce)[*2] ##0 ce |=> !c_q.dis)
    else $error("Disable bit not cleared after two clocks.");
  core_rst_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && $past(ce) |-> c_q.core_rst == $past(c_q.cr_s2))
    else $error("Core reset does not follow the reset chain.");
  cmd_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    c_q.req.exec |-> $past(c_q.pg_s2))
    else $error("Command executed outside programming mode.");
endmodule
`default_nettype wire

// *** spa_unused_note.sv ***
`default_nettype none
`default_nettype wire

// *** spa_scan_ctl.sv ***
// Scan controller model for the far side of the scan port.
// Assumes the test calls its tasks; tck stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module spa_scan_ctl (
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo
);
  logic [15:0] got;
  // Only the four scan pins are used, and tck idles low.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One tck period; tdo is taken just before the rising edge that moves it.
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #16;
    o = tdo;
    tck = 1'b1;
    #16;
    tck = 1'b0;
  endtask
  // Five ones reach Test-Logic-Reset from anywhere; a zero parks in Run-Test/Idle.
  task automatic idle();
    logic o;
    repeat (5) tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
  endtask
  // Extra tck cycles parked in Run-Test/Idle let chip-side results cross.
  task automatic run_idle(input int k);
    logic o;
    repeat (k) tick(1'b0, ~tdi, o);
  endtask
  // Scan n bits low bit first from idle, back to idle through Update.
  task automatic scan(input logic ir, input logic [15:0] d, input int n);
    logic o;
    got = 16'h0000;
    tick(1'b1, ~tdi, o);
    if (ir) begin
      tick(1'b1, ~tdi, o);
    end
    tick(1'b0, ~tdi, o);
    tick(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], o);
      got[i] = o;
    end
    tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
  endtask
endmodule
`default_nettype wire

// *** scan_port_programming_access_test.sv ***
// Self-checking bench for the scan port programming access block.
// Assumes the scan controller model drives the link side.
`timescale 1ns/1ps
`default_nettype none
module scan_port_programming_access_test;
  localparam logic [15:0] SIG = 16'h5a3c;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fuse = 1'b1;
  logic ext_rst_n = 1'b1;
  logic disable_wr = 1'b0;
  logic disable_wdata = 1'b0;
  logic [14:0] nvm_result = 15'h0000;
  logic nvm_result_valid = 1'b0;
  logic ce = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, dis_bit, tap_pins_owned, core_rst, prog_mode;
  spa_pkg::spa_nvm_req_t nvm_req;
  int miscompares = 0;
  int checks_done = 0;
  int execs = 0;
  int cycles = 0;
  int n;
  spa_scan_ctl p (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  spa_scan_port #(.PEN_SIG(SIG)) i_spa_scan_port (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .scan_port_enable_fuse(fuse), .ext_rst_n(ext_rst_n), .disable_wr(disable_wr),
    .disable_wdata(disable_wdata), .scan_port_disable_bit(dis_bit),
    .tap_pins_owned(tap_pins_owned), .core_rst(core_rst), .prog_mode(prog_mode),
    .nvm_req(nvm_req), .nvm_result(nvm_result), .nvm_result_valid(nvm_result_valid));
  // Chip clock, execute pulse count and a hang guard.
  always #12.5 clk = ~clk;
  // Execute pulses are counted on the falling edge, away from their launch.
  always @(negedge clk) begin
    if (nvm_req.exec === 1'b1) execs++;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR at %0t: %s", $time, what);
    end
  endtask
  task automatic waitc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic t_reset_chain();
    p.scan(1'b1, 16'h000c, 4);
    check(p.got[3:0] === 4'h1, "ir capture");
    p.scan(1'b0, 16'h0001, 1);
    check(tdo_oe === 1'b0, "oe idle");
    waitc(8);
    check(core_rst === 1'b1, "core reset on");
    p.scan(1'b0, 16'h0000, 1);
    check(p.got[0] === 1'b1, "reset bit out");
    waitc(8);
    check(core_rst === 1'b0, "core reset off");
    $display("test reset chain done");
  endtask
  task automatic t_bypass();
    p.scan(1'b1, 16'h0003, 4);
    p.scan(1'b0, 16'h00a5, 9);
    check(p.got[8:0] === {8'ha5, 1'b0}, "bypass path");
    $display("test bypass done");
  endtask
  task automatic t_enable();
    n = execs;
    p.scan(1'b1, 16'h0005, 4);
    p.scan(1'b0, 16'h1abc, 15);
    waitc(10);
    check(execs == n && prog_mode === 1'b0, "locked command");
    p.scan(1'b1, 16'h0004, 4);
    p.scan(1'b0, SIG ^ 16'h8000, 16);
    waitc(8);
    check(prog_mode === 1'b0, "bad signature");
    p.scan(1'b0, SIG, 16);
    waitc(8);
    check(prog_mode === 1'b1, "good signature");
    $display("test enable done");
  endtask
  task automatic t_command();
    p.scan(1'b1, 16'h0005, 4);
    n = execs;
    p.scan(1'b0, 16'h2d69, 15);
    waitc(10);
    check(execs == n + 1 && nvm_req.cmd === 15'h2d69, "command run");
    nvm_result <= 15'h4b1e;
    nvm_result_valid <= 1'b1;
    @(posedge clk);
    nvm_result_valid <= 1'b0;
    waitc(4);
    p.run_idle(4);
    p.scan(1'b0, 16'h0000, 15);
    check(p.got[14:0] === 15'h4b1e, "result out");
    $display("test command done");
  endtask
  task automatic t_disable();
    @(posedge clk);
    disable_wdata <= 1'b1;
    disable_wr <= 1'b1;
    @(posedge clk);
    disable_wr <= 1'b0;
    waitc(3);
    check(tap_pins_owned === 1'b0, "port disabled");
    // Forced re-enable is fine here: the port serves programming only.
    ext_rst_n <= 1'b0;
    waitc(2);
    check(dis_bit === 1'b1, "early clear");
    waitc(6);
    check(dis_bit === 1'b0 && tap_pins_owned === 1'b1, "reset re-enable");
    ext_rst_n <= 1'b1;
    fuse <= 1'b0;
    waitc(5);
    check(tap_pins_owned === 1'b0, "fuse off");
    // With the clock enable low, a write and the fuse are both ignored.
    fuse <= 1'b1;
    ce <= 1'b0;
    disable_wr <= 1'b1;
    waitc(3);
    check(dis_bit === 1'b0 && tap_pins_owned === 1'b0, "frozen");
    disable_wr <= 1'b0;
    ce <= 1'b1;
    waitc(4);
    check(dis_bit === 1'b0 && tap_pins_owned === 1'b1, "fuse on");
    $display("test disable done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Reset with tck running, then the scenarios in turn.
  initial begin
    fork
      waitc(5);
      p.idle();
    join
    @(posedge clk);
    sys_rst <= 1'b0;
    waitc(10);
    p.idle();
    t_reset_chain();
    t_bypass();
    t_enable();
    t_command();
    t_disable();
    report_and_stop();
  end
endmodule
`default_nettype wire
